// *** hdl/panel_memory_service_access.v ***
// Summary of operation
// - upper item to address lamps, lower to data
// - auxiliary registers shown via source bus only
// - lamps lit only while processor stopped
// - load ORs data switches with source bus
// - base view gates nothing onto source bus
// - system reset forces switch step two
// - service function 1111, steps 0100/0101/0110
// - address entry count zero only advances
// - counts one to four load digits, MSD first
// - after count four go to read state
// - read state reads, shows, restores character
// - write state writes held character each press
// - address view shows relative address register
// - stop-on-state executes one state per press
// - function bump increments function counter
// - step bump increments step counter
// - partition bump increments partition counter
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "panel_consts.vh"
module panel_memory_service_access (
   input  wire        core_clk,         // 25 MHz clock
   input  wire        reset,            // async reset, active high
   input  wire [3:0]  avs_address,      // byte address
   input  wire        avs_read,         // read request
   input  wire        avs_write,        // write request
   input  wire [31:0] avs_writedata,    // write data
   output wire [31:0] avs_readdata,     // read data
   output wire        avs_waitrequest,  // stall
   input  wire [5:0]  dataSwitch,       // data switch pins
   input  wire [1:0]  displaySel,       // display selector pins
   input  wire [2:0]  modeSel,          // mode selector pins
   input  wire        advanceBtn,       // advance pushbutton pin
   input  wire        loadBtn,          // load pushbutton pin
   input  wire        resetBtn,         // system reset pin
   input  wire        cpuStopped,       // processor is stopped
   input  wire [15:0] baseAddr,         // processor base register
   input  wire [5:0]  auxLength,        // aux length register
   input  wire [5:0]  auxCount,         // aux counter
   input  wire [5:0]  auxExtra,         // aux extra register
   input  wire [5:0]  memRdData,        // core read data
   input  wire        memDone,          // core access complete
   output wire        memRead,          // core read request
   output wire        memWrite,         // core write request
   output wire [13:0] memAddr,          // core address
   output wire [5:0]  memWrData,        // core write data
   output wire [15:0] addrLamps,        // address lamp drivers
   output wire [5:0]  dataLamps,        // data lamp drivers
   output wire [3:0]  funcCode,         // function indicator
   output wire [3:0]  stepCode,         // step indicator
   output wire        stateStep,        // run one processor state
   output wire        sysResetOut       // power-fail style reset
);
   localparam MEM_IDLE    = 2'h0;
   localparam MEM_READ    = 2'h1;
   localparam MEM_RESTORE = 2'h2;
   localparam MEM_WRITE   = 2'h3;

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   reg  [5:0]  swA_q,  swB_q;
   reg  [1:0]  selA_q, selB_q;
   reg  [2:0]  modA_q, modB_q;
   reg  [3:0]  func_q;
   reg  [3:0]  step_q;
   reg  [2:0]  seq_q;
   reg         partTens_q;
   reg  [3:0]  partUnits_q;
   reg  [15:0] relAddr_q;
   reg  [5:0]  charPair_q;
   reg  [1:0]  memState_q;
   reg         memRead_q;
   reg         memWrite_q;
   reg  [13:0] memAddr_q;
   reg  [5:0]  memWrData_q;
   reg  [15:0] addrLamps_q;
   reg  [5:0]  dataLamps_q;
   reg         stateStep_q;
   reg         sysReset_q;
   reg  [31:0] rdData_q;
   reg         waitReq_q;
   reg  [2:0]  softCmd_q;
   reg  [5:0]  srcBus;
   reg  [15:0] resultBus;
   reg  [31:0] rdMux;
   wire [2:0]  btnRaw;
   wire [2:0]  btnPulse;
   wire        advPulse;
   wire        loadPulse;
   wire        rstPulse;
   wire        busy;
   wire [13:0] linAddr;
   wire        regWrite;

   // -----------------------------------------------------------------
   // pushbuttons and switches
   // -----------------------------------------------------------------
   assign btnRaw = {resetBtn, loadBtn, advanceBtn};

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gBtn
         panel_button_pulse uPulse (
            .core_clk   (core_clk),
            .reset      (reset),
            .rawPress   (btnRaw[g]),
            .pressPulse (btnPulse[g])
         );
      end
   endgenerate

   assign advPulse  = btnPulse[`CMD_ADV]  | softCmd_q[`CMD_ADV];
   assign loadPulse = btnPulse[`CMD_LOAD] | softCmd_q[`CMD_LOAD];
   assign rstPulse  = btnPulse[`CMD_RST]  | softCmd_q[`CMD_RST];
   assign busy      = (memState_q != MEM_IDLE);

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         swA_q  <= 6'h00;
         swB_q  <= 6'h00;
         selA_q <= `VIEW_BASE;
         selB_q <= `VIEW_BASE;
         modA_q <= 3'h0;
         modB_q <= 3'h0;
      end else begin
         swA_q  <= dataSwitch;
         swB_q  <= swA_q;
         selA_q <= displaySel;
         selB_q <= selA_q;
         modA_q <= modeSel;
         modB_q <= modA_q;
      end
   end

   // -----------------------------------------------------------------
   // display buses
   // -----------------------------------------------------------------
   always @* begin
      srcBus    = 6'h00;
      resultBus = baseAddr;
      case (selB_q)
         `VIEW_BASE: begin
            srcBus    = 6'h00;
            resultBus = baseAddr;
         end
         `VIEW_RELADDR: begin
            srcBus    = auxLength;
            resultBus = relAddr_q;
         end
         `VIEW_PART: begin
            srcBus    = auxCount;
            resultBus = {3'h0, partTens_q, partUnits_q, 8'h00};
         end
         `VIEW_STATE: begin
            srcBus    = auxExtra;
            resultBus = {1'b0, seq_q, 4'h0, func_q, step_q};
         end
         default: begin
            srcBus    = 6'h00;
            resultBus = baseAddr;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // core address from the four BCD digits
   // -----------------------------------------------------------------
   assign linAddr = {10'h000, relAddr_q[15:12]} * `W1000
                  + {10'h000, relAddr_q[11:8]}  * `W100
                  + {10'h000, relAddr_q[7:4]}   * `W10
                  + {10'h000, relAddr_q[3:0]};

   function [15:0] bcdInc;
      input [15:0] v;
      integer i;
      reg     c;
      begin
         bcdInc = v;
         c      = 1'b1;
         for (i = 0; i < 4; i = i + 1) begin
            if (c) begin
               if (v[i*4 +: 4] == `BCD_NINE) begin
                  bcdInc[i*4 +: 4] = 4'h0;
               end else begin
                  bcdInc[i*4 +: 4] = v[i*4 +: 4] + `BCD_ONE;
                  c = 1'b0;
               end
            end
         end
      end
   endfunction

   // -----------------------------------------------------------------
   // panel state, counters and core service
   // -----------------------------------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         func_q      <= `FUNC_SWITCH;
         step_q      <= `STEP_SW_TWO;
         seq_q       <= `SEQ_FIRST;
         partTens_q  <= 1'b0;
         partUnits_q <= `UNITS_RST;
         relAddr_q   <= `RELADDR_RST;
         charPair_q  <= `CHAR_RST;
         memState_q  <= MEM_IDLE;
         memRead_q   <= 1'b0;
         memWrite_q  <= 1'b0;
         memAddr_q   <= 14'h0000;
         memWrData_q <= `CHAR_RST;
         stateStep_q <= 1'b0;
         sysReset_q  <= 1'b0;
      end else if (rstPulse) begin
         func_q      <= `FUNC_SWITCH;
         step_q      <= `STEP_SW_TWO;
         seq_q       <= `SEQ_FIRST;
         partTens_q  <= 1'b0;
         partUnits_q <= `UNITS_RST;
         relAddr_q   <= `RELADDR_RST;
         charPair_q  <= `CHAR_RST;
         memState_q  <= MEM_IDLE;
         memRead_q   <= 1'b0;
         memWrite_q  <= 1'b0;
         stateStep_q <= 1'b0;
         sysReset_q  <= 1'b1;
      end else begin
         stateStep_q <= 1'b0;
         sysReset_q  <= 1'b0;
         if (loadPulse && !busy) begin
            charPair_q <= swB_q | srcBus;
         end
         case (memState_q)
            MEM_IDLE: begin
               if (advPulse) begin
                  case (modB_q)
                     `MODE_FUNC_BUMP: begin
                        func_q <= func_q + 4'h1;
                     end
                     `MODE_STEP_BUMP: begin
                        step_q <= step_q + 4'h1;
                        seq_q  <= `SEQ_FIRST;
                     end
                     `MODE_PART_BUMP: begin
                        if (partUnits_q == `BCD_NINE) begin
                           partUnits_q <= 4'h0;
                           partTens_q  <= ~partTens_q;
                        end else begin
                           partUnits_q <= partUnits_q + `BCD_ONE;
                        end
                     end
                     `MODE_STOP_STATE: begin
                        if (func_q == `FUNC_SERVICE &&
                            step_q == `STEP_ADDR_ENTRY) begin
                           case (seq_q)
                              3'h1: relAddr_q[15:12] <= charPair_q[3:0];
                              3'h2: relAddr_q[11:8]  <= charPair_q[3:0];
                              3'h3: relAddr_q[7:4]   <= charPair_q[3:0];
                              3'h4: relAddr_q[3:0]   <= charPair_q[3:0];
                              default: ;
                           endcase
                           if (seq_q == `SEQ_LAST) begin
                              step_q <= `STEP_READ;
                              seq_q  <= `SEQ_FIRST;
                           end else begin
                              seq_q <= seq_q + 3'h1;
                           end
                        end else if (func_q == `FUNC_SERVICE &&
                                     step_q == `STEP_READ) begin
                           memAddr_q  <= linAddr;
                           memRead_q  <= 1'b1;
                           memState_q <= MEM_READ;
                        end else if (func_q == `FUNC_SERVICE &&
                                     step_q == `STEP_WRITE) begin
                           memAddr_q   <= linAddr;
                           memWrData_q <= charPair_q;
                           memWrite_q  <= 1'b1;
                           memState_q  <= MEM_WRITE;
                        end else begin
                           stateStep_q <= 1'b1;
                        end
                     end
                     default: ;
                  endcase
               end
            end
            MEM_READ: begin
               if (memDone) begin
                  memRead_q   <= 1'b0;
                  charPair_q  <= memRdData;
                  memWrData_q <= memRdData;
                  memWrite_q  <= 1'b1;
                  memState_q  <= MEM_RESTORE;
               end
            end
            MEM_RESTORE, MEM_WRITE: begin
               if (memDone) begin
                  memWrite_q <= 1'b0;
                  relAddr_q  <= bcdInc(relAddr_q);
                  memState_q <= MEM_IDLE;
               end
            end
            default: memState_q <= MEM_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // lamps
   // -----------------------------------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         addrLamps_q <= 16'h0000;
         dataLamps_q <= 6'h00;
      end else if (cpuStopped) begin
         addrLamps_q <= resultBus;
         dataLamps_q <= (selB_q == `VIEW_BASE) ? charPair_q : srcBus;
      end else begin
         addrLamps_q <= 16'h0000;
         dataLamps_q <= 6'h00;
      end
   end

   // -----------------------------------------------------------------
   // register bus slave
   // -----------------------------------------------------------------
   assign regWrite = avs_write & ~waitReq_q;

   always @* begin
      rdMux = 32'h00000000;
      case (avs_address)
         `REG_STATE:   rdMux = {15'h0000, busy, partTens_q, partUnits_q,
                                seq_q, func_q, step_q};
         `REG_RELADDR: rdMux = {16'h0000, relAddr_q};
         `REG_CHAR:    rdMux = {26'h0000000, charPair_q};
         default:      rdMux = 32'h00000000;
      endcase
   end

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         waitReq_q <= 1'b1;
         rdData_q  <= 32'h00000000;
         softCmd_q <= 3'h0;
      end else begin
         softCmd_q <= 3'h0;
         if ((avs_read | avs_write) && waitReq_q) begin
            waitReq_q <= 1'b0;
            rdData_q  <= avs_read ? rdMux : 32'h00000000;
         end else begin
            waitReq_q <= 1'b1;
         end
         if (regWrite && avs_address == `REG_CMD) begin
            softCmd_q <= avs_writedata[2:0];
         end
      end
   end

   assign avs_readdata    = rdData_q;
   assign avs_waitrequest = waitReq_q;
   assign memRead         = memRead_q;
   assign memWrite        = memWrite_q;
   assign memAddr         = memAddr_q;
   assign memWrData       = memWrData_q;
   assign addrLamps       = addrLamps_q;
   assign dataLamps       = dataLamps_q;
   assign funcCode        = func_q;
   assign stepCode        = step_q;
   assign stateStep       = stateStep_q;
   assign sysResetOut     = sysReset_q;
endmodule // panel_memory_service_access
`default_nettype wire

// *** hdl/panel_consts.vh ***
`ifndef PANEL_CONSTS_VH
`define PANEL_CONSTS_VH
// -----------------------------------------------------------------
// state codes
// -----------------------------------------------------------------
`define FUNC_SERVICE     4'hF
`define FUNC_SWITCH      4'h3
`define STEP_SW_TWO      4'h2
`define STEP_ADDR_ENTRY  4'h4
`define STEP_READ        4'h5
`define STEP_WRITE       4'h6
`define SEQ_FIRST        3'h0
`define SEQ_LAST         3'h4
// -----------------------------------------------------------------
// mode selector positions
// -----------------------------------------------------------------
`define MODE_STOP_STATE  3'h4
`define MODE_FUNC_BUMP   3'h5
`define MODE_STEP_BUMP   3'h6
`define MODE_PART_BUMP   3'h7
// -----------------------------------------------------------------
// display selector positions
// -----------------------------------------------------------------
`define VIEW_BASE        2'h0
`define VIEW_RELADDR     2'h1
`define VIEW_PART        2'h2
`define VIEW_STATE       2'h3
// -----------------------------------------------------------------
// register map and command bits
// -----------------------------------------------------------------
`define REG_STATE        4'h0
`define REG_RELADDR      4'h4
`define REG_CHAR         4'h8
`define REG_CMD          4'hC
`define CMD_ADV          0
`define CMD_LOAD         1
`define CMD_RST          2
// -----------------------------------------------------------------
// reset values and arithmetic constants
// -----------------------------------------------------------------
`define RELADDR_RST      16'h0000
`define CHAR_RST         6'h00
`define UNITS_RST        4'h0
`define BCD_NINE         4'h9
`define BCD_ONE          4'h1
`define W1000            14'h3E8
`define W100             14'h064
`define W10              14'h00A
`endif

// *** hdl/panel_button_pulse.v ***
`timescale 1ns/1ps
`default_nettype none
module panel_button_pulse (
   input  wire core_clk,   // clock
   input  wire reset,      // async reset, active high
   input  wire rawPress,   // pushbutton level from the pin
   output wire pressPulse  // one clock per press
);
   reg syncA_q;
   reg syncB_q;
   reg last_q;
   reg pulse_q;

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         syncA_q <= 1'b0;
         syncB_q <= 1'b0;
         last_q  <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         syncA_q <= rawPress;
         syncB_q <= syncA_q;
         last_q  <= syncB_q;
         pulse_q <= syncB_q & ~last_q;
      end
   end

   assign pressPulse = pulse_q;
endmodule // panel_button_pulse
`default_nettype wire

// *** tb/core_memory_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_memory_model (
   input  wire logic        core_clk,   // clock
   input  wire logic        reset,      // async reset
   input  wire logic        memRead,    // read request
   input  wire logic        memWrite,   // write request
   input  wire logic [13:0] memAddr,    // address
   input  wire logic [5:0]  memWrData,  // write data
   output var  logic [5:0]  memRdData,  // read data
   output var  logic        memDone,    // access complete
   output var  logic [13:0] lastAddr,   // last written address
   output var  logic [5:0]  lastData,   // last written data
   output var  logic [7:0]  wrCount     // writes seen
);
   logic [5:0] mem [0:16383];
   logic [2:0] wait_q;
   logic       slow_q;
   logic       gap_q;
   initial for (int i = 0; i < 16384; i++) mem[i] = i[5:0] ^ 6'h15;
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         {memRdData, memDone, lastAddr, lastData, wrCount} <= '0;
         {wait_q, slow_q, gap_q} <= '0;
      end else begin
         memDone <= 1'b0;
         gap_q <= 1'b0;
         // read data toggles between answers so stale values never match
         memRdData <= ~memRdData;
         if (gap_q || !(memRead || memWrite)) begin
            // alternate prompt and slow answers
            wait_q <= slow_q ? 3'h4 : 3'h1;
         end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
         end else begin
            memDone <= 1'b1;
            gap_q <= 1'b1;
            slow_q <= !slow_q;
            memRdData <= mem[memAddr];
            if (memWrite) begin
               mem[memAddr] <= memWrData;
               lastAddr <= memAddr;
               lastData <= memWrData;
               wrCount <= wrCount + 8'h01;
            end
         end
      end
   end
endmodule // core_memory_model
`default_nettype wire

// *** tb/panel_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "panel_consts.vh"
module panel_checker (
   input wire logic        core_clk,    // clock
   input wire logic        reset,       // async reset
   input wire logic        cpuStopped,  // processor stopped
   input wire logic        memRead,     // core read
   input wire logic        memWrite,    // core write
   input wire logic        memDone,     // core done
   input wire logic [5:0]  memRdData,   // core read data
   input wire logic [5:0]  memWrData,   // core write data
   input wire logic [13:0] memAddr,     // core address
   input wire logic [15:0] addrLamps,   // address lamps
   input wire logic [5:0]  dataLamps,   // data lamps
   input wire logic [3:0]  funcCode,    // function counter
   input wire logic [3:0]  stepCode,    // step counter
   input wire logic        stateStep,   // one-state request
   input wire logic        sysResetOut  // reset pulse
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // ----------------------------------------------
   // lamps and counters
   // ----------------------------------------------
   property p_dark;
      !cpuStopped |=> addrLamps == 16'h0000 && dataLamps == 6'h00;
   endproperty
   a_dark: assert property (p_dark) else $error("lamps lit");
   property p_step;
      stepCode != $past(stepCode) |->
         stepCode == $past(stepCode) + 4'h1 || stepCode == `STEP_SW_TWO;
   endproperty
   a_step: assert property (p_step) else $error("step jump");
   property p_func;
      funcCode != $past(funcCode) |->
         funcCode == $past(funcCode) + 4'h1 || funcCode == `FUNC_SWITCH;
   endproperty
   a_func: assert property (p_func) else $error("func jump");
   property p_pulse;
      stateStep |=> !stateStep;
   endproperty
   a_pulse: assert property (p_pulse) else $error("long step");
   property p_sysrst;
      sysResetOut |-> ##[0:1]
         (funcCode == `FUNC_SWITCH && stepCode == `STEP_SW_TWO);
   endproperty
   a_sysrst: assert property (p_sysrst) else $error("no reset");
   property p_onesys;
      sysResetOut |=> !sysResetOut;
   endproperty
   a_onesys: assert property (p_onesys) else $error("long rst");
   // ----------------------------------------------
   // core accesses
   // ----------------------------------------------
   property p_accst;
      memRead || memWrite |-> funcCode == `FUNC_SERVICE &&
         (stepCode == `STEP_READ || stepCode == `STEP_WRITE);
   endproperty
   a_accst: assert property (p_accst) else $error("bad access");
   property p_restore;
      memRead && memDone |=>
         memWrite && !memRead && memWrData == $past(memRdData);
   endproperty
   a_restore: assert property (p_restore) else $error("no wb");
   property p_hold;
      memRead && !memDone |=> memRead && $stable(memAddr);
   endproperty
   a_hold: assert property (p_hold) else $error("read drop");
   property p_wrend;
      memWrite && memDone |=> !memWrite;
   endproperty
   a_wrend: assert property (p_wrend) else $error("write on");
endmodule // panel_checker
bind panel_memory_service_access panel_checker chk (.core_clk, .reset,
   .cpuStopped, .memRead, .memWrite, .memDone, .memRdData, .memWrData,
   .memAddr, .addrLamps, .dataLamps, .funcCode, .stepCode, .stateStep,
   .sysResetOut);
`default_nettype wire

// *** tb/panel_memory_service_access_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "panel_consts.vh"
module panel_memory_service_access_bench;
   logic        core_clk, reset, avs_read, avs_write, avs_waitrequest;
   logic        advanceBtn, loadBtn, resetBtn, cpuStopped, memDone;
   logic        memRead, memWrite, stateStep, sysResetOut;
   logic [3:0]  avs_address, funcCode, stepCode;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [5:0]  dataSwitch, auxLength, auxCount, auxExtra, memRdData;
   logic [5:0]  memWrData, dataLamps, lastData;
   logic [1:0]  displaySel;
   logic [2:0]  modeSel;
   logic [15:0] baseAddr, addrLamps;
   logic [13:0] memAddr, lastAddr;
   logic [7:0]  wrCount;
   int          num_errors, checks, stepPulses, sysPulses;
   panel_memory_service_access dut (.core_clk, .reset, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .dataSwitch, .displaySel, .modeSel, .advanceBtn,
      .loadBtn, .resetBtn, .cpuStopped, .baseAddr, .auxLength, .auxCount,
      .auxExtra, .memRdData, .memDone, .memRead, .memWrite, .memAddr,
      .memWrData, .addrLamps, .dataLamps, .funcCode, .stepCode,
      .stateStep, .sysResetOut);
   core_memory_model mem (.core_clk, .reset, .memRead, .memWrite,
      .memAddr, .memWrData, .memRdData, .memDone, .lastAddr, .lastData,
      .wrCount);
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (stateStep === 1'b1) stepPulses++;
      if (sysResetOut === 1'b1) sysPulses++;
   end
   // ----------------------------------------------
   // helpers
   // ----------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task rdChk(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task press(input int b);
      @(posedge core_clk);
      case (b)
         0: advanceBtn <= 1'b1;
         1: loadBtn <= 1'b1;
         default: resetBtn <= 1'b1;
      endcase
      repeat (4) @(posedge core_clk);
      {advanceBtn, loadBtn, resetBtn} <= 3'h0;
      repeat (6) @(posedge core_clk);
      while ((memRead | memWrite) !== 1'b0) begin
         @(posedge core_clk);
      end
      repeat (3) @(posedge core_clk);
   endtask
   task setIn(input logic [2:0] m, input logic [1:0] v);
      @(posedge core_clk);
      modeSel <= m;
      displaySel <= v;
      repeat (4) @(posedge core_clk);
   endtask
   task loadChar(input logic [5:0] s);
      @(posedge core_clk);
      dataSwitch <= s;
      repeat (3) @(posedge core_clk);
      press(1);
   endtask
   // ----------------------------------------------
   // scenarios
   // ----------------------------------------------
   task t_reset;
      chk(funcCode, `FUNC_SWITCH);
      chk(stepCode, `STEP_SW_TWO);
      rdChk(`REG_CHAR, 32'h0);
      bus(1'b1, `REG_STATE, 32'hFFFFFFFF);
      rdChk(`REG_STATE, 32'h32);
      rdChk(`REG_CMD, 32'h0);
      rdChk(4'h2, 32'h0);
   endtask
   task t_lamps;
      setIn(`MODE_STOP_STATE, `VIEW_BASE);
      loadChar(6'h2A);
      rdChk(`REG_CHAR, 32'h2A);
      chk(addrLamps, 16'hA5C3);
      chk(dataLamps, 6'h2A);
      @(posedge core_clk) cpuStopped <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk({addrLamps, dataLamps}, 22'h0);
      @(posedge core_clk) cpuStopped <= 1'b1;
      setIn(`MODE_STOP_STATE, `VIEW_RELADDR);
      chk(dataLamps, 6'h11);
      rdChk(`REG_CHAR, 32'h2A);
      loadChar(6'h06);
      rdChk(`REG_CHAR, 32'h17);
      setIn(`MODE_STOP_STATE, `VIEW_STATE);
      chk(addrLamps, 16'h0032);
      chk(dataLamps, 6'h2B);
   endtask
   task t_stop;
      press(0);
      chk(stepPulses, 1);
      bus(1'b1, `REG_CMD, 32'h1);
      repeat (4) @(posedge core_clk);
      chk(stepPulses, 2);
      chk(funcCode, `FUNC_SWITCH);
   endtask
   task t_part;
      setIn(`MODE_PART_BUMP, `VIEW_PART);
      repeat (13) press(0);
      chk(addrLamps, 16'h1300);
      chk(dataLamps, 6'h22);
      repeat (7) press(0);
      chk(addrLamps, 16'h0000);
      chk(stepPulses, 2);
   endtask
   task t_nav;
      setIn(`MODE_FUNC_BUMP, `VIEW_BASE);
      repeat (12) press(0);
      chk(funcCode, `FUNC_SERVICE);
      setIn(`MODE_STEP_BUMP, `VIEW_BASE);
      repeat (2) press(0);
      chk(stepCode, `STEP_ADDR_ENTRY);
      chk(stepPulses, 2);
   endtask
   task t_entry;
      setIn(`MODE_STOP_STATE, `VIEW_BASE);
      press(0);
      rdChk(`REG_STATE, 32'h1F4);
      chk(wrCount, 8'h0);
      for (int d = 1; d <= 4; d++) begin
         loadChar(d[5:0]);
         press(0);
      end
      rdChk(`REG_RELADDR, 32'h1234);
      chk(stepCode, `STEP_READ);
      chk(funcCode, `FUNC_SERVICE);
      setIn(`MODE_STOP_STATE, `VIEW_RELADDR);
      chk(addrLamps, 16'h1234);
   endtask
   task t_read;
      setIn(`MODE_STOP_STATE, `VIEW_BASE);
      for (int k = 0; k < 2; k++) begin
         press(0);
         chk(dataLamps, 6'h07 ^ k[5:0]);
         chk(lastAddr, 14'h4D2 + k[13:0]);
         chk(lastData, 6'h07 ^ k[5:0]);
      end
      chk(stepCode, `STEP_READ);
   endtask
   task t_write;
      setIn(`MODE_STEP_BUMP, `VIEW_BASE);
      press(0);
      chk(stepCode, `STEP_WRITE);
      setIn(`MODE_STOP_STATE, `VIEW_BASE);
      loadChar(6'h3C);
      press(0);
      press(0);
      chk(wrCount, 8'h04);
      chk(lastAddr, 14'h4D5);
      chk(lastData, 6'h3C);
   endtask
   task t_sysrst;
      setIn(`MODE_FUNC_BUMP, `VIEW_BASE);
      press(0);
      chk(funcCode, 4'h0);
      press(2);
      chk(sysPulses, 1);
      chk(funcCode, `FUNC_SWITCH);
      chk(stepCode, `STEP_SW_TWO);
      rdChk(`REG_RELADDR, 32'h0);
      rdChk(`REG_CHAR, 32'h0);
      bus(1'b1, `REG_CMD, 32'h4);
      repeat (4) @(posedge core_clk);
      chk(sysPulses, 2);
   endtask
   task results;
      if (num_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      {core_clk, reset, avs_read, avs_write} = 4'h4;
      {advanceBtn, loadBtn, resetBtn, cpuStopped} = 4'h1;
      {avs_address, avs_writedata, dataSwitch} = '0;
      {displaySel, modeSel} = '0;
      {num_errors, checks, stepPulses, sysPulses} = '0;
      baseAddr = 16'hA5C3;
      auxLength = 6'h11;
      auxCount = 6'h22;
      auxExtra = 6'h2B;
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      t_reset;
      t_lamps;
      t_stop;
      t_part;
      t_nav;
      t_entry;
      t_read;
      t_write;
      t_sysrst;
      results;
   end
   initial begin
      #(40 * 20000);
      num_errors++;
      results;
   end
endmodule // panel_memory_service_access_bench
`default_nettype wire
